// file: hdl/rss_strobe_top.sv
// Receiver status strobes, event marks, frequency outputs and time-sync pulse
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module rss_strobe_top
  import rss_pkg::*;
#(
  parameter int HW = 16,
  parameter int BOOT_CYCLES = BOOT_CYC,
  parameter int SYNC_PERIOD_RST = SYNC_PERIOD_CYC,
  parameter int SYNC_WIDTH_RST = SYNC_WIDTH_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic mark_input_1,
  input wire logic mark_input_2,
  input wire logic mark_input_3,
  input wire logic mark_input_4,
  input wire logic external_reset_n,
  input wire logic rx_error,
  input wire logic rx_fatal,
  input wire logic rx_pos_ok,
  input wire logic gnss_epoch,
  output logic error_out,
  output logic command_ready,
  output logic position_valid,
  output logic time_sync_pulse,
  output logic freq_output_1,
  output logic freq_output_2,
  output logic freq_output_3,
  output logic freq_output_4,
  output logic [3:0] mark_event,
  output logic irq
);
  localparam logic [31:0] BOOT_LAST = 32'(BOOT_CYCLES - 1);
  localparam logic [31:0] SYNC_PERIOD_INIT = 32'(SYNC_PERIOD_RST);
  localparam logic [31:0] SYNC_WIDTH_INIT = 32'(SYNC_WIDTH_RST);

  // Register state
  logic [CTRL_W-1:0] ctrl_r;
  logic [INT_W-1:0] int_status_r;
  logic [INT_W-1:0] int_en_r;
  logic [31:0] sync_period_r;
  logic [31:0] sync_width_r;
  logic [HW-1:0] freq_half_r [4];
  logic [31:0] mark_time_r [4];
  logic [31:0] time_now_r;

  // Bus state
  logic avs_waitrequest_r;
  logic [31:0] avs_readdata_r;
  logic req;
  logic wr_en;
  logic [5:0] word_addr;
  logic [31:0] rd_mux;

  // Card state
  rss_state_t state_r;
  logic [31:0] boot_cnt_r;
  logic card_rst;
  logic running;
  logic [31:0] sync_cnt_r;
  logic sync_active;

  // Output flops
  logic error_out_r;
  logic command_ready_r;
  logic position_valid_r;
  logic time_sync_pulse_r;
  logic [3:0] freq_out_r;
  logic [3:0] mark_event_r;
  logic irq_r;

  logic [3:0] mark_pins;
  logic [3:0] mark_evt;
  logic [3:0] wave;
  logic [INT_W-1:0] int_set;
  logic [INT_W-1:0] int_clr;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wdata,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wdata[8*b +: 8];
      end
    end
    be_merge = res;
  endfunction

  assign mark_pins = {mark_input_4, mark_input_3, mark_input_2, mark_input_1};

  // Mark filters and frequency generators, one pair per channel
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      rss_ch_if #(.HW(HW)) ch ();
      assign ch.pol = ctrl_r[CTRL_MARK_POL_LSB + gi];
      assign ch.half = freq_half_r[gi];
      assign mark_evt[gi] = ch.evt;
      assign wave[gi] = ch.wave;

      rss_mark_filter #(.MIN_CYC(MARK_MIN_CYC)) u_mark (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .pin(mark_pins[gi]),
        .ch(ch.filt)
      );

      rss_freq_gen #(.HW(HW)) u_freq (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .ch(ch.gen)
      );
    end
  endgenerate

  // External reset: synchronised and held longer than the minimum before it acts
  rss_ch_if #(.HW(HW)) rst_ch ();
  assign rst_ch.pol = 1'b0;
  assign rst_ch.half = '0;
  assign card_rst = rst_ch.lvl;

  rss_mark_filter #(.MIN_CYC(RST_MIN_CYC)) u_ext_rst (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pin(external_reset_n),
    .ch(rst_ch.filt)
  );

  // Avalon request decode
  assign req = avs_read | avs_write;
  assign wr_en = avs_write && !avs_waitrequest_r;
  assign word_addr = {avs_address[5:2], 2'b00};

  // One wait cycle, then the answer edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest_r <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest_r <= !(req && avs_waitrequest_r);
    end
  end

  // Read multiplexer; unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (word_addr)
      OFS_CTRL: rd_mux = 32'(ctrl_r);
      OFS_STATE: rd_mux = {25'h0000000, card_rst, position_valid_r, error_out_r, command_ready_r,
                           time_sync_pulse_r, state_r};
      OFS_INT_STATUS: rd_mux = 32'(int_status_r);
      OFS_INT_ENABLE: rd_mux = 32'(int_en_r);
      OFS_SYNC_PERIOD: rd_mux = sync_period_r;
      OFS_SYNC_WIDTH: rd_mux = sync_width_r;
      OFS_FREQ_HALF0: rd_mux = 32'(freq_half_r[0]);
      OFS_FREQ_HALF0 + 6'h04: rd_mux = 32'(freq_half_r[1]);
      OFS_FREQ_HALF0 + 6'h08: rd_mux = 32'(freq_half_r[2]);
      OFS_FREQ_HALF0 + 6'h0c: rd_mux = 32'(freq_half_r[3]);
      OFS_MARK_TIME0: rd_mux = mark_time_r[0];
      OFS_MARK_TIME0 + 6'h04: rd_mux = mark_time_r[1];
      OFS_MARK_TIME0 + 6'h08: rd_mux = mark_time_r[2];
      OFS_MARK_TIME0 + 6'h0c: rd_mux = mark_time_r[3];
      OFS_TIME_NOW: rd_mux = time_now_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured at the edge that drops waitrequest
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata_r <= 32'h0000_0000;
    end else if (clk_en && avs_read && avs_waitrequest_r) begin
      avs_readdata_r <= rd_mux;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= CTRL_RST;
      int_en_r <= INT_RST;
      sync_period_r <= SYNC_PERIOD_INIT;
      sync_width_r <= SYNC_WIDTH_INIT;
    end else if (clk_en && wr_en) begin
      unique case (word_addr)
        OFS_CTRL: ctrl_r <= CTRL_W'(be_merge(32'(ctrl_r), avs_writedata, avs_byteenable));
        OFS_INT_ENABLE: int_en_r <= INT_W'(be_merge(32'(int_en_r), avs_writedata, avs_byteenable));
        OFS_SYNC_PERIOD: sync_period_r <= be_merge(sync_period_r, avs_writedata, avs_byteenable);
        OFS_SYNC_WIDTH: sync_width_r <= be_merge(sync_width_r, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
  end

  // Frequency half periods, one word per output
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        freq_half_r[i] <= '0;
      end
    end else if (clk_en && wr_en) begin
      for (int i = 0; i < 4; i++) begin
        if (word_addr == OFS_FREQ_HALF0 + 6'(4 * i)) begin
          freq_half_r[i] <= HW'(be_merge(32'(freq_half_r[i]), avs_writedata, avs_byteenable));
        end
      end
    end
  end

  // Free-running time base and mark time records
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      time_now_r <= 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
        mark_time_r[i] <= 32'h0000_0000;
      end
    end else if (clk_en) begin
      time_now_r <= time_now_r + 32'h0000_0001;
      for (int i = 0; i < 4; i++) begin
        if (mark_evt[i]) begin
          mark_time_r[i] <= time_now_r;
        end
      end
    end
  end

  // Boot, run and restart sequencing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= RSS_BOOT;
      boot_cnt_r <= 32'h0000_0000;
    end else if (clk_en) begin
      if (card_rst) begin
        state_r <= RSS_BOOT;
        boot_cnt_r <= 32'h0000_0000;
      end else begin
        unique case (state_r)
          RSS_BOOT, RSS_REBOOT: begin
            if (boot_cnt_r == BOOT_LAST) begin
              state_r <= RSS_RUN;
              boot_cnt_r <= 32'h0000_0000;
            end else begin
              boot_cnt_r <= boot_cnt_r + 32'h0000_0001;
            end
          end
          RSS_RUN: begin
            if (rx_fatal) begin
              state_r <= RSS_REBOOT;
            end
            boot_cnt_r <= 32'h0000_0000;
          end
          default: begin
            state_r <= RSS_BOOT;
            boot_cnt_r <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  assign running = (state_r == RSS_RUN) && !card_rst && !rx_fatal;

  // Status strobes, all low outside running
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      command_ready_r <= 1'b0;
      error_out_r <= 1'b0;
      position_valid_r <= 1'b0;
    end else if (clk_en) begin
      command_ready_r <= running;
      error_out_r <= running && rx_error;
      position_valid_r <= running && rx_pos_ok && !rx_error;
    end
  end

  // Time-sync counter restarts on every GNSS epoch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_cnt_r <= 32'h0000_0000;
    end else if (clk_en) begin
      if (gnss_epoch || sync_cnt_r >= sync_period_r - 32'h0000_0001) begin
        sync_cnt_r <= 32'h0000_0000;
      end else begin
        sync_cnt_r <= sync_cnt_r + 32'h0000_0001;
      end
    end
  end

  assign sync_active = (sync_period_r != 32'h0000_0000) && (sync_cnt_r < sync_width_r);

  // Pin drivers; polarity applied to the sync and frequency outputs, not to mark events
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      time_sync_pulse_r <= 1'b1;
      freq_out_r <= 4'hf;
      mark_event_r <= 4'h0;
    end else if (clk_en) begin
      time_sync_pulse_r <= rss_pol(sync_active, ctrl_r[CTRL_SYNC_POL]);
      for (int i = 0; i < 4; i++) begin
        freq_out_r[i] <= rss_pol(wave[i], ctrl_r[CTRL_FREQ_POL_LSB + i]);
      end
      mark_event_r <= mark_evt;
    end
  end

  // Interrupt sources and write-one clear; a set wins over a clear
  always_comb begin
    int_set = INT_RST;
    int_set[INT_MARK_LSB +: 4] = mark_evt;
    int_set[INT_ERR] = running && rx_error && !error_out_r;
    int_set[INT_FATAL] = (state_r == RSS_RUN) && rx_fatal && !card_rst;
    int_set[INT_SYNC] = sync_active && (sync_cnt_r == 32'h0000_0000);
    int_clr = INT_RST;
    if (wr_en && word_addr == OFS_INT_CLEAR) begin
      int_clr = INT_W'(be_merge(32'h0000_0000, avs_writedata, avs_byteenable));
    end
  end

  // Sticky status and level interrupt
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_status_r <= INT_RST;
      irq_r <= 1'b0;
    end else if (clk_en) begin
      int_status_r <= (int_status_r & ~int_clr) | int_set;
      irq_r <= |(((int_status_r & ~int_clr) | int_set) & int_en_r);
    end
  end

  assign avs_waitrequest = avs_waitrequest_r;
  assign avs_readdata = avs_readdata_r;
  assign error_out = error_out_r;
  assign command_ready = command_ready_r;
  assign position_valid = position_valid_r;
  assign time_sync_pulse = time_sync_pulse_r;
  assign freq_output_1 = freq_out_r[0];
  assign freq_output_2 = freq_out_r[1];
  assign freq_output_3 = freq_out_r[2];
  assign freq_output_4 = freq_out_r[3];
  assign mark_event = mark_event_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// file: hdl/rss_pkg.sv
// Shared constants, types and helpers of the receiver strobe block
package rss_pkg;

  // Clock and timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_NS = 25;
  localparam int MARK_MIN_NS = 150;
  localparam int MARK_MIN_CYC = MARK_MIN_NS / CLK_NS + 1;
  localparam int RST_MIN_US = 20;
  localparam int RST_MIN_CYC = RST_MIN_US * 1000 / CLK_NS + 1;
  localparam int BOOT_US = 100;
  localparam int BOOT_CYC = BOOT_US * 1000 / CLK_NS;
  localparam int SYNC_PERIOD_MS = 1000;
  localparam int SYNC_PERIOD_CYC = SYNC_PERIOD_MS * (CLK_HZ / 1000);
  localparam int SYNC_WIDTH_US = 1000;
  localparam int SYNC_WIDTH_CYC = SYNC_WIDTH_US * (CLK_HZ / 1_000_000);

  // Register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STATE = 6'h04;
  localparam logic [5:0] OFS_INT_STATUS = 6'h08;
  localparam logic [5:0] OFS_INT_CLEAR = 6'h0c;
  localparam logic [5:0] OFS_INT_ENABLE = 6'h10;
  localparam logic [5:0] OFS_SYNC_PERIOD = 6'h14;
  localparam logic [5:0] OFS_SYNC_WIDTH = 6'h18;
  localparam logic [5:0] OFS_FREQ_HALF0 = 6'h1c;
  localparam logic [5:0] OFS_MARK_TIME0 = 6'h2c;
  localparam logic [5:0] OFS_TIME_NOW = 6'h3c;

  // Control fields and reset values
  localparam int CTRL_MARK_POL_LSB = 0;
  localparam int CTRL_FREQ_POL_LSB = 4;
  localparam int CTRL_SYNC_POL = 8;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

  // Interrupt bits
  localparam int INT_MARK_LSB = 0;
  localparam int INT_ERR = 4;
  localparam int INT_FATAL = 5;
  localparam int INT_SYNC = 6;
  localparam int INT_W = 7;
  localparam logic [INT_W-1:0] INT_RST = 7'h00;

  typedef enum logic [1:0] {
    RSS_BOOT = 2'b00,
    RSS_RUN = 2'b01,
    RSS_REBOOT = 2'b11
  } rss_state_t;

  // Polarity bit 0 means active low; converts pin level and active level both ways
  function automatic logic rss_pol(input logic lvl, input logic pol);
    rss_pol = pol ? lvl : ~lvl;
  endfunction

endpackage

// file: hdl/rss_ch_if.sv
// Per-channel signals between the strobe top and its filter and generator
`timescale 1ns/100ps
`default_nettype none
interface rss_ch_if #(
  parameter int HW = 16
);
  logic pol;
  logic evt;
  logic lvl;
  logic [HW-1:0] half;
  logic wave;
  modport filt (input pol, output evt, output lvl);
  modport gen (input half, output wave);
  modport top (output pol, output half, input evt, input lvl, input wave);
endinterface
`default_nettype wire

// file: hdl/rss_mark_filter.sv
// Pin synchroniser, width filter and leading-edge detector
`timescale 1ns/100ps
`default_nettype none
module rss_mark_filter
  import rss_pkg::*;
#(
  parameter int MIN_CYC = MARK_MIN_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic pin,
  rss_ch_if.filt ch
);
  localparam int CW = $clog2(MIN_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(MIN_CYC - 1);
  localparam logic [CW-1:0] CNT_SAT = CW'(MIN_CYC);

  logic sync1_r;
  logic sync2_r;
  logic [CW-1:0] cnt_r;
  logic active;

  // Two flops before anything looks at the pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else if (clk_en) begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
    end
  end

  assign active = rss_pol(sync2_r, ch.pol);

  // Count consecutive active samples, saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      if (!active) begin
        cnt_r <= '0;
      end else if (cnt_r != CNT_SAT) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // One event per qualifying pulse, plus the qualified level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ch.evt <= 1'b0;
      ch.lvl <= 1'b0;
    end else if (clk_en) begin
      ch.evt <= active && (cnt_r == CNT_LAST);
      ch.lvl <= active && (cnt_r >= CNT_LAST);
    end
  end
endmodule
`default_nettype wire

// file: hdl/rss_freq_gen.sv
// Square-wave generator with a programmable half period
`timescale 1ns/100ps
`default_nettype none
module rss_freq_gen
  import rss_pkg::*;
#(
  parameter int HW = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  rss_ch_if.gen ch
);
  logic [HW-1:0] cnt_r;

  // Half period of zero stops the wave (0 Hz)
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      ch.wave <= 1'b0;
    end else if (clk_en) begin
      if (ch.half == '0) begin
        cnt_r <= '0;
        ch.wave <= 1'b0;
      end else if (cnt_r >= ch.half - 1'b1) begin
        cnt_r <= '0;
        ch.wave <= ~ch.wave;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/rss_strobe_monitor.sv
// Port-level checker of the strobe block
`timescale 1ns/100ps
`default_nettype none
module rss_strobe_monitor
  import rss_pkg::*;
#(
  parameter int BOOT_CYCLES = BOOT_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic external_reset_n,
  input wire logic mark_input_1,
  input wire logic rx_error,
  input wire logic rx_fatal,
  input wire logic rx_pos_ok,
  input wire logic gnss_epoch,
  input wire logic error_out,
  input wire logic command_ready,
  input wire logic position_valid,
  input wire logic time_sync_pulse,
  input wire logic [3:0] mark_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  int unsigned up_cnt;
  // Cycles since reset release, saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) up_cnt <= 0;
    else if (up_cnt < 100000) up_cnt <= up_cnt + 1;
  end
  sequence card_idle_s; external_reset_n [*4]; endsequence
  sequence fatal_s; rx_fatal && command_ready; endsequence
  sequence all_low_s; !command_ready && !error_out && !position_valid; endsequence
  AST_ERR_CAUSE: assert property ($rose(error_out) |-> $past(rx_error))
    else $error("error output rose without a receiver error");
  AST_POS_DROP: assert property ($rose(error_out) |-> !position_valid)
    else $error("position valid kept when error rose");
  AST_POS_CAUSE: assert property (position_valid |-> $past(rx_pos_ok) && !$past(rx_error))
    else $error("position valid without a solution");
  AST_BOOT_HOLD: assert property (command_ready |-> up_cnt >= BOOT_CYCLES)
    else $error("command ready during boot");
  AST_FATAL: assert property (fatal_s |=> all_low_s [*8])
    else $error("strobes not all low during restart");
  AST_RECOV: assert property (card_idle_s ##0 (rx_error && !rx_fatal && command_ready) |=> command_ready)
    else $error("command ready dropped on recoverable error");
  AST_MARK_PULSE: assert property (|mark_event |=> (mark_event & $past(mark_event)) == 4'h0)
    else $error("mark event longer than one cycle");
  AST_MARK_WIDTH: assert property (mark_event[0] |-> $past(mark_input_1, 4) == $past(mark_input_1, 8))
    else $error("mark event on a short pulse");
  AST_SYNC_EPOCH: assert property (gnss_epoch |-> ##2 !time_sync_pulse)
    else $error("sync pulse not started at the epoch");
endmodule
bind rss_strobe_top rss_strobe_monitor #(.BOOT_CYCLES(BOOT_CYCLES)) rss_strobe_monitor_i (.clk(clk),
  .arst_n(arst_n), .external_reset_n(external_reset_n), .mark_input_1(mark_input_1), .rx_error(rx_error),
  .rx_fatal(rx_fatal), .rx_pos_ok(rx_pos_ok), .gnss_epoch(gnss_epoch), .error_out(error_out),
  .command_ready(command_ready), .position_valid(position_valid), .time_sync_pulse(time_sync_pulse),
  .mark_event(mark_event));
`default_nettype wire

// file: sim/rss_host_model.sv
// Host controller model driving card reset and mark pins
`timescale 1ns/100ps
`default_nettype none
module rss_host_model (
  input wire logic clk,
  output logic external_reset_n,
  output logic [3:0] mark_pins
);
  // Idle levels: reset released, marks inactive for active-low sensing
  initial begin
    external_reset_n = 1'b1;
    mark_pins = 4'hf;
  end
  // Holds the card reset low for a number of cycles
  task automatic hold_reset(input int cyc);
    @(posedge clk);
    external_reset_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    external_reset_n <= 1'b1;
  endtask
  // Drives one mark pin to a level, then back to its opposite
  task automatic mark_pulse(input int idx, input logic act, input int cyc);
    @(posedge clk);
    mark_pins[idx] <= act;
    repeat (cyc) @(posedge clk);
    mark_pins[idx] <= ~act;
  endtask
endmodule
`default_nettype wire

// file: sim/rss_strobe_top_tb.sv
// Self-checking bench of the receiver strobe block
`timescale 1ns/100ps
`default_nettype none
module rss_strobe_top_tb;
  import rss_pkg::*;
  logic clk, arst_n, clk_en, avs_read, avs_write, rx_error, rx_fatal, rx_pos_ok, gnss_epoch, external_reset_n;
  logic avs_waitrequest, error_out, command_ready, position_valid, time_sync_pulse, irq;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] mark_event, mark_pins, fo, be;
  int err_total = 0, checks_done = 0, cyc = 0, n, e0;
  int ev_cnt [4] = '{0, 0, 0, 0};
  rss_host_model rss_host_model_i (.clk(clk), .external_reset_n(external_reset_n), .mark_pins(mark_pins));
  rss_strobe_top #(.BOOT_CYCLES(20), .SYNC_PERIOD_RST(100), .SYNC_WIDTH_RST(10)) rss_strobe_top_i (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mark_input_1(mark_pins[0]), .mark_input_2(mark_pins[1]),
    .mark_input_3(mark_pins[2]), .mark_input_4(mark_pins[3]), .external_reset_n(external_reset_n),
    .rx_error(rx_error), .rx_fatal(rx_fatal), .rx_pos_ok(rx_pos_ok), .gnss_epoch(gnss_epoch),
    .error_out(error_out), .command_ready(command_ready), .position_valid(position_valid),
    .time_sync_pulse(time_sync_pulse), .freq_output_1(fo[0]), .freq_output_2(fo[1]), .freq_output_3(fo[2]),
    .freq_output_4(fo[3]), .mark_event(mark_event), .irq(irq));
  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Mark event counting and run timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++) if (mark_event[i] === 1'b1) ev_cnt[i] <= ev_cnt[i] + 1;
    if (cyc == 10000) begin
      err_total++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wait_rdy;
    for (int k = 0; k < 2000 && command_ready !== 1'b1; k++) @(posedge clk);
  endtask
  // Main sequence
  initial begin
    arst_n = 1'b0;
    {avs_read, avs_write, rx_error, rx_fatal, rx_pos_ok, gnss_epoch} = 6'h00;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    clk_en = 1'b1;
    be = 4'hf;
    repeat (10) @(posedge clk);
    chk("ready in reset", command_ready, 0);
    chk("freq idle", fo, 4'hf);
    arst_n <= 1'b1;
    wait_rdy;
    chk("ready after boot", command_ready, 1);
    bus(0, OFS_CTRL, 0);
    chk("ctrl reset", rd, 0);
    $display("Test boot done");
    for (int i = 0; i < 4; i++) begin
      rss_host_model_i.mark_pulse(i, 1'b0, 8);
      rss_host_model_i.mark_pulse(i, 1'b0, 5);
      repeat (15) @(posedge clk);
      chk("mark events", ev_cnt[i], 1);
    end
    bus(0, OFS_INT_STATUS, 0);
    chk("mark status", rd & 32'hf, 32'hf);
    bus(1, OFS_INT_ENABLE, 32'hf);
    repeat (2) @(posedge clk);
    chk("irq set", irq, 1);
    bus(1, OFS_INT_CLEAR, 32'hf);
    repeat (2) @(posedge clk);
    chk("irq cleared", irq, 0);
    bus(1, OFS_CTRL, 32'h1);
    repeat (15) @(posedge clk);
    e0 = ev_cnt[0];
    rss_host_model_i.mark_pulse(0, 1'b0, 5);
    repeat (15) @(posedge clk);
    chk("active high mark", ev_cnt[0], e0 + 1);
    bus(1, OFS_CTRL, 0);
    $display("Test marks done");
    rx_pos_ok <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pos valid", position_valid, 1);
    chk("error low", error_out, 0);
    bus(1, OFS_INT_ENABLE, 32'h10);
    rx_error <= 1'b1;
    repeat (3) @(posedge clk);
    chk("error high", error_out, 1);
    chk("pos dropped", position_valid, 0);
    chk("ready kept", command_ready, 1);
    chk("error irq", irq, 1);
    bus(1, OFS_INT_CLEAR, 32'h10);
    repeat (2) @(posedge clk);
    chk("error irq cleared", irq, 0);
    rx_fatal <= 1'b1;
    @(posedge clk);
    rx_fatal <= 1'b0;
    repeat (2) @(posedge clk);
    chk("fatal all low", {command_ready, error_out, position_valid}, 0);
    wait_rdy;
    chk("ready after restart", command_ready, 1);
    rx_error <= 1'b0;
    bus(1, OFS_STATE, 32'hffffffff);
    bus(0, OFS_STATE, 0);
    chk("state read only", rd & 32'h3b, 32'h29);
    $display("Test status done");
    rss_host_model_i.hold_reset(100);
    repeat (4) @(posedge clk);
    chk("short card reset", command_ready, 1);
    rss_host_model_i.hold_reset(900);
    chk("ready in card reset", command_ready, 0);
    wait_rdy;
    chk("ready after card reset", command_ready, 1);
    $display("Test card reset done");
    for (int i = 0; i < 4; i++) begin
      bus(1, OFS_FREQ_HALF0 + 6'(4 * i), 32'(i + 2));
      for (n = 0; n < 20 && fo[i] !== 1'b0; n++) @(posedge clk);
      for (n = 0; n < 20 && fo[i] !== 1'b1; n++) @(posedge clk);
      for (n = 0; n < 20 && fo[i] !== 1'b0; n++) @(posedge clk);
      chk("freq half period", n, i + 2);
      bus(1, OFS_FREQ_HALF0 + 6'(4 * i), 0);
      repeat (6) @(posedge clk);
      chk("freq stopped", fo[i], 1);
    end
    bus(1, OFS_CTRL, 32'hf0);
    repeat (3) @(posedge clk);
    chk("freq polarity", fo, 4'h0);
    bus(1, OFS_CTRL, 0);
    $display("Test freq done");
    bus(1, OFS_SYNC_WIDTH, 32'h4);
    bus(1, OFS_SYNC_PERIOD, 32'h14);
    for (n = 0; n < 200 && time_sync_pulse !== 1'b1; n++) @(posedge clk);
    gnss_epoch <= 1'b1;
    @(posedge clk);
    gnss_epoch <= 1'b0;
    for (n = 0; n < 10 && time_sync_pulse !== 1'b0; n++) @(posedge clk);
    for (n = 0; n < 20 && time_sync_pulse !== 1'b1; n++) @(posedge clk);
    chk("sync width", n, 4);
    for (n = 0; n < 200 && time_sync_pulse !== 1'b0; n++) @(posedge clk);
    chk("sync period gap", n, 16);
    $display("Test sync done");
    // Only byte lane 1 written: sync polarity bit set, low byte kept
    be <= 4'h2;
    bus(1, OFS_CTRL, 32'h1ff);
    be <= 4'hf;
    bus(0, OFS_CTRL, 0);
    chk("ctrl lane write", rd, 32'h100);
    bus(1, OFS_CTRL, 0);
    // Time base advances only on enabled edges between the two captures
    bus(0, OFS_TIME_NOW, 0);
    e0 = rd;
    clk_en <= 1'b0;
    repeat (10) @(posedge clk);
    clk_en <= 1'b1;
    bus(0, OFS_TIME_NOW, 0);
    chk("time frozen", rd - e0, 3);
    $display("Test enable done");
    complete_run;
  end
endmodule
`default_nettype wire
